// ===== logic/scan_primitives.sv
// Purpose : edge detectors, latches, comparators and variable store
//           evaluated once per program scan; the store is read every cycle and written on any cycle outside the clear sweep
// Assumes : SCAN_STEP_I is a one-cycle pulse, inputs stable for the scan
// Notes   : a scan takes three cycles: edges, latches, compares

`timescale 1ns/1ps
`default_nettype none

module scan_primitives
	import scan_pkg::*;
#(
	parameter int N_EDGE  = 2,
	parameter int N_LATCH = 2,
	parameter int N_VARS  = 16,
	parameter int VAR_AW  = 4
)(
	input  wire logic                      CLK_I,
	input  wire logic                      RSTN_I,
	input  wire logic                      SCAN_STEP_I,
	input  wire logic [N_EDGE-1:0]         FALL_CLK_I,
	input  wire logic [N_EDGE-1:0]         RISE_CLK_I,
	input  wire logic [N_LATCH-1:0]        LATCH_SET_I,
	input  wire logic [N_LATCH-1:0]        LATCH_RESET_I,
	input  wire logic [N_LATCH-1:0]        LOAD_SET_I,
	input  wire logic [N_LATCH-1:0]        LOAD_RESET_I,
	input  wire logic [N_LATCH-1:0]        LOAD_DATA_I,
	input  wire logic [N_LATCH-1:0]        LOAD_EN_I,
	input  wire operand_type_e             OPERAND_TYPE_I,
	input  wire logic [2:0]                OPERAND_COUNT_I,
	input  wire logic [MAX_OPERANDS*OPERAND_W-1:0] COMPARATOR_OPERANDS_I,
	input  wire logic                      VAR_WE_I,
	input  wire logic [VAR_AW-1:0]         VAR_ADDR_I,
	input  wire logic [OPERAND_W-1:0]      VAR_WDATA_I,
	input  wire logic                      VAR_RETAIN_I,
	output logic [N_EDGE-1:0]              FALL_OUT_O,
	output logic [N_EDGE-1:0]              RISE_OUT_O,
	output logic [N_LATCH-1:0]             LATCH_OUT_O,
	output logic [N_LATCH-1:0]             LOAD_OUT_O,
	output logic                           EQUAL_OUT_O,
	output logic                           GE_OUT_O,
	output logic                           GT_OUT_O,
	output logic                           SCAN_DONE_O,
	output logic                           BUSY_O,
	output logic [OPERAND_W-1:0]           VAR_RDATA_O
);

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	// two flops so every process leaves reset on one clean edge; the
	// raw pin still asserts reset at once
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ----------------------------------------------------------------
	// scan sequencer
	// ----------------------------------------------------------------
	// stages run in layout order; later stages see the results of
	// earlier ones within the same scan
	scan_state_e          state;
	scan_state_e          next_state;
	logic [VAR_AW-1:0]    clear_addr;
	logic                 clear_last;

	assign clear_last = (clear_addr == VAR_AW'(N_VARS - 1));

	// ----------------------------------------------------------------
	// stage strobes
	// ----------------------------------------------------------------
	// one decode of the one-hot state per stage; inputs are read only
	// while the owning strobe is high, so changes between scans are
	// ignored
	logic clear_stage;
	logic edge_stage;
	logic latch_stage;
	logic compare_stage;

	assign clear_stage   = (state == ST_CLEAR);
	assign edge_stage    = (state == ST_EDGE);
	assign latch_stage   = (state == ST_LATCH);
	assign compare_stage = (state == ST_COMPARE);

	always_comb begin
		case (state)
			ST_CLEAR:   next_state = clear_last ? ST_IDLE : ST_CLEAR;
			ST_IDLE:    next_state = SCAN_STEP_I ? ST_EDGE : ST_IDLE;
			ST_EDGE:    next_state = ST_LATCH;
			ST_LATCH:   next_state = ST_COMPARE;
			ST_COMPARE: next_state = ST_IDLE;
			default:    next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_CLEAR;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			SCAN_DONE_O <= 1'b0;
			BUSY_O      <= 1'b1;
		end else begin
			// busy follows the next state, so it is high in the cycle
			// after a step is taken and drops in the cycle that done rises
			SCAN_DONE_O <= compare_stage;
			BUSY_O      <= (next_state != ST_IDLE);
		end
	end

	// ----------------------------------------------------------------
	// edge detectors
	// ----------------------------------------------------------------
	// outputs load in the edge stage only, so a detected edge stands
	// for exactly one scan and clears on the next one
	logic [N_EDGE-1:0] fall_prev;
	logic [N_EDGE-1:0] rise_prev;

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			fall_prev  <= '0;
			rise_prev  <= '0;
			FALL_OUT_O <= '0;
			RISE_OUT_O <= '0;
		end else if (edge_stage) begin
			fall_prev  <= FALL_CLK_I;
			rise_prev  <= RISE_CLK_I;
			FALL_OUT_O <= fall_prev & ~FALL_CLK_I;
			RISE_OUT_O <= ~rise_prev & RISE_CLK_I;
		end
	end

	// ----------------------------------------------------------------
	// latches
	// ----------------------------------------------------------------
	// reset-dominant decode shared by both latch kinds, so the loadable
	// one with load low cannot drift from the plain one
	function automatic logic latch_next(
		input logic set,
		input logic reset,
		input logic last
	);
		if (reset) begin
			return 1'b0;
		end
		if (set) begin
			return 1'b1;
		end
		return last;
	endfunction : latch_next

	genvar gi;
	generate
		for (gi = 0; gi < N_LATCH; gi++) begin : g_latch
			always_ff @(posedge CLK_I or negedge rst_n) begin
				if (!rst_n) begin
					LATCH_OUT_O[gi] <= TRUTH_FALSE;
				end else if (latch_stage) begin
					LATCH_OUT_O[gi] <= latch_next(LATCH_SET_I[gi],
						LATCH_RESET_I[gi], LATCH_OUT_O[gi]);
				end
			end

			always_ff @(posedge CLK_I or negedge rst_n) begin
				if (!rst_n) begin
					LOAD_OUT_O[gi] <= TRUTH_FALSE;
				end else if (latch_stage) begin
					if (LOAD_RESET_I[gi]) begin
						LOAD_OUT_O[gi] <= 1'b0;
					end else if (LOAD_EN_I[gi]) begin
						LOAD_OUT_O[gi] <= LOAD_DATA_I[gi];
					end else begin
						LOAD_OUT_O[gi] <= latch_next(LOAD_SET_I[gi],
							LOAD_RESET_I[gi], LOAD_OUT_O[gi]);
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// comparators
	// ----------------------------------------------------------------
	// each operand is compared with the first; equality of all follows
	// from equality of each with the first
	logic [MAX_OPERANDS-1:1] pair_equal;
	logic [MAX_OPERANDS-1:1] pair_greater;
	logic [2:0]              op_count;
	logic                    all_equal;

	// a count outside two to five is clamped rather than refused, so a
	// bad count can never reach past the operand lanes
	always_comb begin
		if (OPERAND_COUNT_I < MIN_OPERANDS_C) begin
			op_count = MIN_OPERANDS_C;
		end else if (OPERAND_COUNT_I > MAX_OPERANDS_C) begin
			op_count = MAX_OPERANDS_C;
		end else begin
			op_count = OPERAND_COUNT_I;
		end
	end

	generate
		for (gi = 1; gi < MAX_OPERANDS; gi++) begin : g_cmp
			operand_compare u_cmp (
				.a_i       (COMPARATOR_OPERANDS_I[OPERAND_W-1:0]),
				.b_i       (COMPARATOR_OPERANDS_I[gi*OPERAND_W +: OPERAND_W]),
				.type_i    (OPERAND_TYPE_I),
				.equal_o   (pair_equal[gi]),
				.greater_o (pair_greater[gi])
			);
		end
	endgenerate

	always_comb begin
		all_equal = 1'b1;
		for (int k = 1; k < MAX_OPERANDS; k++) begin
			if (k < int'(op_count) && !pair_equal[k]) begin
				all_equal = 1'b0;
			end
		end
	end

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			EQUAL_OUT_O <= 1'b0;
			GE_OUT_O    <= 1'b0;
			GT_OUT_O    <= 1'b0;
		end else if (compare_stage) begin
			EQUAL_OUT_O <= all_equal;
			GE_OUT_O    <= pair_greater[1] | pair_equal[1];
			GT_OUT_O    <= pair_greater[1];
		end
	end

	// ----------------------------------------------------------------
	// variable store
	// ----------------------------------------------------------------
	// words and retain flags have no reset so they survive a reset
	// the sweep after release clears only unflagged words.
	// limitation: flags start unknown in simulation until first written
	logic [OPERAND_W-1:0] var_mem [N_VARS];
	logic [N_VARS-1:0]    var_retain;

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			clear_addr <= '0;
		end else if (clear_stage && !clear_last) begin
			clear_addr <= clear_addr + 1'b1;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (clear_stage) begin
			if (!var_retain[clear_addr]) begin
				var_mem[clear_addr] <= VAR_CLEAR_VALUE;
			end
		end else if (VAR_WE_I) begin
			var_mem[VAR_ADDR_I]    <= VAR_WDATA_I;
			var_retain[VAR_ADDR_I] <= VAR_RETAIN_I;
		end
	end

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			VAR_RDATA_O <= '0;
		end else begin
			VAR_RDATA_O <= var_mem[VAR_ADDR_I];
		end
	end

endmodule : scan_primitives

`default_nettype wire

// ===== logic/scan_pkg.sv
// Purpose : shared constants and types for the scan-driven logic primitives
// Assumes : one 100 MHz clock, scan steps arrive as one-cycle enables
// Notes   : operand words are carried at the widest width, 32 bits

package scan_pkg;

	// ----------------------------------------------------------------
	// operand types and widths
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		TRUTH_VALUE_TYPE   = 3'h0,
		SIGNED_WORD_TYPE   = 3'h1,
		SIGNED_LONG_TYPE   = 3'h2,
		UNSIGNED_WORD_TYPE = 3'h3,
		REAL_TYPE          = 3'h4
	} operand_type_e;

	localparam int OPERAND_W   = 32;
	localparam int WORD_W      = 16;
	localparam int REAL_SIGN_B = 31;
	localparam int MAX_OPERANDS = 5;
	localparam int MIN_OPERANDS = 2;
	localparam logic [2:0] MIN_OPERANDS_C = 3'h2;
	localparam logic [2:0] MAX_OPERANDS_C = 3'h5;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [OPERAND_W-1:0] VAR_CLEAR_VALUE = 32'h0000_0000;
	localparam logic                 TRUTH_FALSE     = 1'b0;

	// ----------------------------------------------------------------
	// scan sequencer states, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_CLEAR   = 5'h01,
		ST_IDLE    = 5'h02,
		ST_EDGE    = 5'h04,
		ST_LATCH   = 5'h08,
		ST_COMPARE = 5'h10
	} scan_state_e;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 10000;

endpackage : scan_pkg

// ===== logic/operand_compare.sv
// Purpose : compares two operands of one type, giving equal and greater
// Assumes : both operands share the type given (the program converts)
// Notes   : real compare ignores not-a-number codes; +0 and -0 are equal

`timescale 1ns/1ps
`default_nettype none

module operand_compare
	import scan_pkg::*;
(
	input  wire logic [OPERAND_W-1:0] a_i,
	input  wire logic [OPERAND_W-1:0] b_i,
	input  wire operand_type_e        type_i,
	output logic                      equal_o,
	output logic                      greater_o
);

	// ----------------------------------------------------------------
	// real ordering key
	// ----------------------------------------------------------------
	// flipping the bits of negatives and setting the top bit of positives
	// makes an unsigned compare follow the numeric order of single-precision values
	function automatic logic [OPERAND_W-1:0] real_key(
		input logic [OPERAND_W-1:0] v
	);
		logic [OPERAND_W-1:0] k;
		k = v;
		if (v[REAL_SIGN_B - 1:0] == '0) begin
			k = 32'h8000_0000;
		end else if (v[REAL_SIGN_B]) begin
			k = ~v;
		end else begin
			k = v | 32'h8000_0000;
		end
		return k;
	endfunction : real_key

	logic [OPERAND_W-1:0] key_a;
	logic [OPERAND_W-1:0] key_b;

	assign key_a = real_key(a_i);
	assign key_b = real_key(b_i);

	// ----------------------------------------------------------------
	// per-type compare
	// ----------------------------------------------------------------
	always_comb begin
		case (type_i)
			TRUTH_VALUE_TYPE: begin
				equal_o   = (a_i[0] == b_i[0]);
				greater_o = a_i[0] & ~b_i[0];
			end
			SIGNED_WORD_TYPE: begin
				equal_o   = (a_i[WORD_W-1:0] == b_i[WORD_W-1:0]);
				greater_o = $signed(a_i[WORD_W-1:0]) > $signed(b_i[WORD_W-1:0]);
			end
			SIGNED_LONG_TYPE: begin
				equal_o   = (a_i == b_i);
				greater_o = $signed(a_i) > $signed(b_i);
			end
			UNSIGNED_WORD_TYPE: begin
				equal_o   = (a_i[WORD_W-1:0] == b_i[WORD_W-1:0]);
				greater_o = a_i[WORD_W-1:0] > b_i[WORD_W-1:0];
			end
			REAL_TYPE: begin
				equal_o   = (key_a == key_b);
				greater_o = key_a > key_b;
			end
			default: begin
				equal_o   = 1'b0;
				greater_o = 1'b0;
			end
		endcase
	end

endmodule : operand_compare

`default_nettype wire

// ===== dv/scan_checker.sv
// Purpose : port-level checks of the scan primitives
// Assumes : inputs stay stable through a scan; lane 0 is watched
// Notes   : stage order and the four-cycle scan are fixed by the design
`timescale 1ns/1ps
`default_nettype none
module scan_checker
	import scan_pkg::*;
#(
	parameter int N_EDGE  = 2,
	parameter int N_LATCH = 2
)(
	input wire logic                       CLK_I,
	input wire logic                       RSTN_I,
	input wire logic                       SCAN_STEP_I,
	input wire logic [N_EDGE-1:0]          FALL_CLK_I,
	input wire logic [N_EDGE-1:0]          RISE_CLK_I,
	input wire logic [N_LATCH-1:0]         LATCH_SET_I,
	input wire logic [N_LATCH-1:0]         LATCH_RESET_I,
	input wire logic [N_LATCH-1:0]         LOAD_SET_I,
	input wire logic [N_LATCH-1:0]         LOAD_RESET_I,
	input wire logic [N_LATCH-1:0]         LOAD_DATA_I,
	input wire logic [N_LATCH-1:0]         LOAD_EN_I,
	input wire operand_type_e              OPERAND_TYPE_I,
	input wire logic [MAX_OPERANDS*OPERAND_W-1:0] COMPARATOR_OPERANDS_I,
	input wire logic [N_EDGE-1:0]          FALL_OUT_O,
	input wire logic [N_EDGE-1:0]          RISE_OUT_O,
	input wire logic [N_LATCH-1:0]         LATCH_OUT_O,
	input wire logic [N_LATCH-1:0]         LOAD_OUT_O,
	input wire logic                       EQUAL_OUT_O,
	input wire logic                       GE_OUT_O,
	input wire logic                       GT_OUT_O,
	input wire logic                       SCAN_DONE_O,
	input wire logic                       BUSY_O
);
	logic        prev_rise;
	logic        prev_fall;
	logic        rise_last;
	logic        fall_last;
	logic [63:0] ops_last;
	logic        sc;
	assign sc = SCAN_DONE_O;
	// inputs one cycle back: the caller may change them in the cycle
	// that done is high, so checks read the copy held through the scan
	always_ff @(posedge CLK_I) begin
		rise_last <= RISE_CLK_I[0];
		fall_last <= FALL_CLK_I[0];
		ops_last  <= COMPARATOR_OPERANDS_I[63:0];
	end
	// last scan's edge inputs, mirrors what the detectors keep
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			prev_rise <= 1'h0;
			prev_fall <= 1'h0;
		end else if (sc) begin
			prev_rise <= rise_last;
			prev_fall <= fall_last;
		end
	end
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);
	sequence scan_take; SCAN_STEP_I && !BUSY_O; endsequence
	sequence scan_stages; BUSY_O [*3] ##1 (sc && !BUSY_O); endsequence
	scan_latency_a: assert property (scan_take |=> scan_stages)
		else $error("scan did not finish in four cycles");
	done_pulse_a: assert property (sc |=> !sc)
		else $error("scan done longer than one cycle");
	idle_hold_a: assert property (!BUSY_O && !SCAN_STEP_I |=>
		$stable({RISE_OUT_O, FALL_OUT_O, LATCH_OUT_O, LOAD_OUT_O, EQUAL_OUT_O}))
		else $error("outputs moved outside a scan");
	rise_edge_a: assert property (sc |->
		RISE_OUT_O[0] == (rise_last && !prev_rise))
		else $error("rising detector wrong");
	fall_edge_a: assert property (sc |->
		FALL_OUT_O[0] == (!fall_last && prev_fall))
		else $error("falling detector wrong");
	reset_wins_a: assert property (sc && $past(LATCH_RESET_I[0]) |->
		!LATCH_OUT_O[0]) else $error("latch not cleared by reset");
	latch_set_a: assert property (sc && $past(LATCH_SET_I[0])
		&& !$past(LATCH_RESET_I[0]) |-> LATCH_OUT_O[0])
		else $error("latch not set");
	latch_hold_a: assert property (sc && !$past(LATCH_SET_I[0])
		&& !$past(LATCH_RESET_I[0])
		|-> LATCH_OUT_O[0] == $past(LATCH_OUT_O[0], 4))
		else $error("latch did not hold");
	load_plain_a: assert property (sc && !$past(LOAD_EN_I[0])
		&& !$past(LOAD_RESET_I[0]) && $past(LOAD_SET_I[0])
		|-> LOAD_OUT_O[0]) else $error("loadable not set");
	load_data_a: assert property (sc && $past(LOAD_EN_I[0] || LOAD_RESET_I[0]) |->
		LOAD_OUT_O[0] == $past(LOAD_DATA_I[0] && !LOAD_RESET_I[0]))
		else $error("loadable data or reset wrong");
	long_order_a: assert property (sc && $past(OPERAND_TYPE_I) ==
		SIGNED_LONG_TYPE |-> GE_OUT_O == ($signed(ops_last[31:0]) >=
		$signed(ops_last[63:32])) && GT_OUT_O ==
		($signed(ops_last[31:0]) > $signed(ops_last[63:32])))
		else $error("order compare wrong");
endmodule : scan_checker
bind scan_primitives scan_checker #(.N_EDGE(N_EDGE), .N_LATCH(N_LATCH)) chk_u (
	.CLK_I(CLK_I), .RSTN_I(RSTN_I), .SCAN_STEP_I(SCAN_STEP_I),
	.FALL_CLK_I(FALL_CLK_I), .RISE_CLK_I(RISE_CLK_I),
	.LATCH_SET_I(LATCH_SET_I), .LATCH_RESET_I(LATCH_RESET_I),
	.LOAD_SET_I(LOAD_SET_I), .LOAD_RESET_I(LOAD_RESET_I),
	.LOAD_DATA_I(LOAD_DATA_I), .LOAD_EN_I(LOAD_EN_I),
	.OPERAND_TYPE_I(OPERAND_TYPE_I),
	.COMPARATOR_OPERANDS_I(COMPARATOR_OPERANDS_I),
	.FALL_OUT_O(FALL_OUT_O), .RISE_OUT_O(RISE_OUT_O),
	.LATCH_OUT_O(LATCH_OUT_O), .LOAD_OUT_O(LOAD_OUT_O),
	.EQUAL_OUT_O(EQUAL_OUT_O), .GE_OUT_O(GE_OUT_O), .GT_OUT_O(GT_OUT_O),
	.SCAN_DONE_O(SCAN_DONE_O), .BUSY_O(BUSY_O)
);
`default_nettype wire

// ===== dv/scan_sequencer.sv
// Purpose : model of the program scan sequencer issuing scan steps
// Assumes : caller holds operands stable until the scan reports done
// Notes   : a step is raised once the block reads idle, or after 60 cycles of waiting
`timescale 1ns/1ps
`default_nettype none
module scan_sequencer (
	input  wire logic clk_i,
	input  wire logic busy_i,
	input  wire logic done_i,
	output var  logic step_o
);
	initial step_o = 1'h0;
	task automatic run_scan(output bit ok);
		int n;
		n = 0;
		ok = 1'b0;
		do begin
			@(posedge clk_i);
			#1;
			n++;
		end while (busy_i !== 1'h0 && n < 60);
		step_o = 1'h1;
		@(posedge clk_i);
		#1 step_o = 1'h0;
		for (int i = 0; i < 8 && !ok; i++) begin
			@(posedge clk_i);
			#1 ok = (done_i === 1'h1);
		end
	endtask : run_scan
endmodule : scan_sequencer
`default_nettype wire

// ===== dv/tb_top.sv
// Purpose : self-checking bench of the scan primitives
// Assumes : operand types are matched by the caller
// Notes   : expectations are rebuilt from the primitive rules
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fails++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb_top;
	import scan_pkg::*;
	logic          clk = 1'h0;
	logic          rstn = 1'h0;
	logic          step, eq, ge, gt, done, busy, we = 0, retain = 0;
	logic [1:0]    fclk = 0, rclk = 0, lset = 0, lrst = 0, dset = 0, drst = 0;
	logic [1:0]    ddat = 0, den = 0, fout, rout, lout, dout;
	operand_type_e otype = TRUTH_VALUE_TYPE;
	logic [2:0]    ocnt = 3'h2;
	logic [159:0]  ops = '0;
	logic [3:0]    addr = 0;
	logic [31:0]   wdata = 0, rdata;
	int            fails = 0, checks = 0, cycles = 0;
	bit            ok;
	always #5 clk = ~clk;
	scan_primitives dut_u (.CLK_I(clk), .RSTN_I(rstn), .SCAN_STEP_I(step),
		.FALL_CLK_I(fclk), .RISE_CLK_I(rclk), .LATCH_SET_I(lset),
		.LATCH_RESET_I(lrst), .LOAD_SET_I(dset), .LOAD_RESET_I(drst),
		.LOAD_DATA_I(ddat), .LOAD_EN_I(den), .OPERAND_TYPE_I(otype),
		.OPERAND_COUNT_I(ocnt), .COMPARATOR_OPERANDS_I(ops), .VAR_WE_I(we),
		.VAR_ADDR_I(addr), .VAR_WDATA_I(wdata), .VAR_RETAIN_I(retain),
		.FALL_OUT_O(fout), .RISE_OUT_O(rout), .LATCH_OUT_O(lout),
		.LOAD_OUT_O(dout), .EQUAL_OUT_O(eq), .GE_OUT_O(ge), .GT_OUT_O(gt),
		.SCAN_DONE_O(done), .BUSY_O(busy), .VAR_RDATA_O(rdata));
	scan_sequencer seq_u (.clk_i(clk), .busy_i(busy), .done_i(done),
		.step_o(step));
	task automatic print_verdict;
		if (fails == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			print_verdict();
		end
	end
	task automatic scan;
		seq_u.run_scan(ok);
		`CHK("scan done", 1'b1, ok)
	endtask : scan
	task automatic t_store;
		// writes are refused during the clear sweep, so wait for idle
		do begin
			@(posedge clk);
			#1;
		end while (busy !== 1'h0);
		for (int i = 0; i < 2; i++) begin
			{we, addr, retain} = {1'h1, 4'h3 + 4'(i), 1'(1 - i)};
			wdata = i ? 32'h0bad_f00d : 32'h1234_5678;
			@(posedge clk);
			#1;
		end
		we = 1'h0;
		rstn = 1'h0;
		repeat (6) @(posedge clk);
		#1 rstn = 1'h1;
		repeat (24) @(posedge clk);
		#1 addr = 4'h3;
		@(posedge clk);
		#1 `CHK("retained", 32'h1234_5678, rdata)
		addr = 4'h4;
		@(posedge clk);
		#1 `CHK("cleared", VAR_CLEAR_VALUE, rdata)
	endtask : t_store
	task automatic t_edges;
		logic [1:0] pr, pf;
		logic [1:0] seqv [5] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h1};
		pr = 2'h0;
		pf = 2'h0;
		for (int i = 0; i < 5; i++) begin
			rclk = seqv[i];
			fclk = ~seqv[i];
			scan();
			`CHK("rise", seqv[i] & ~pr, rout)
			`CHK("fall", ~fclk & pf, fout)
			pr = rclk;
			pf = fclk;
		end
	endtask : t_edges
	task automatic t_latch;
		logic le, de;
		logic [3:0] row [8] = '{4'h8, 4'h0, 4'h4, 4'h0, 4'hc, 4'h3, 4'ha, 4'h7};
		le = 1'h0;
		de = 1'h0;
		for (int i = 0; i < 8; i++) begin
			{lset, lrst, den, ddat} = {{2{row[i][3]}}, {2{row[i][2]}},
				{2{row[i][1]}}, {2{row[i][0]}}};
			{dset, drst} = {lset, lrst};
			scan();
			le = lrst[0] ? 1'h0 : (lset[0] ? 1'h1 : le);
			de = drst[0] ? 1'h0 : (den[0] ? ddat[0] : (dset[0] ? 1'h1 : de));
			`CHK("latch", {2{le}}, lout)
			`CHK("loadable", {2{de}}, dout)
		end
	endtask : t_latch
	task automatic cmp(input operand_type_e t, input logic [2:0] n,
		input logic [31:0] a, b, c, input logic [2:0] ex);
		otype = t;
		ocnt = n;
		ops = {c, c, c, b, a};
		scan();
		`CHK("equal", ex[2], eq)
		if (t != TRUTH_VALUE_TYPE)
			`CHK("order", ex[1:0], {ge, gt})
	endtask : cmp
	task automatic t_compare;
		cmp(TRUTH_VALUE_TYPE, 3'h2, 32'h1, 32'h1, 32'h0, 3'h4);
		cmp(TRUTH_VALUE_TYPE, 3'h3, 32'h1, 32'h1, 32'h0, 3'h0);
		cmp(SIGNED_WORD_TYPE, 3'h2, 32'hffff, 32'h1, 32'h0, 3'h0);
		cmp(UNSIGNED_WORD_TYPE, 3'h2, 32'hffff, 32'h1, 32'h0, 3'h3);
		cmp(SIGNED_WORD_TYPE, 3'h5, 32'h7, 32'h7, 32'h8, 3'h2);
		cmp(SIGNED_WORD_TYPE, 3'h7, 32'h7, 32'h7, 32'h8, 3'h2);
		cmp(SIGNED_WORD_TYPE, 3'h0, 32'h7, 32'h7, 32'h8, 3'h6);
		cmp(SIGNED_LONG_TYPE, 3'h5, 32'h5, 32'h5, 32'h5, 3'h6);
		cmp(SIGNED_LONG_TYPE, 3'h2, 32'h8000_0000, 32'h7fff_ffff, 32'h0, 3'h0);
		cmp(REAL_TYPE, 3'h2, 32'h8000_0000, 32'h0, 32'h0, 3'h6);
		cmp(REAL_TYPE, 3'h2, 32'hbf80_0000, 32'h3f80_0000, 32'h0, 3'h0);
		cmp(REAL_TYPE, 3'h2, 32'h3f80_0000, 32'hbf80_0000, 32'h0, 3'h3);
	endtask : t_compare
	initial begin
		repeat (6) @(posedge clk);
		#1 rstn = 1'h1;
		t_store();
		t_edges();
		t_latch();
		t_compare();
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
